// ### rtl/gpp_port.sv
// 16-bit general-purpose port with AHB-Lite register slave
// What this block does
// - Two-bit mode: input, output, alternate, analog
// - Output type bit: push-pull or open-drain
// - Pull field: none, pull-up, pull-down
// - Speed field sets output driver speed
// - Reset: inputs, no pull, alternates off
// - Debug pins 14/13 reset to alternate, pull-down on 14, pull-up on 13 (port A only)
// - Input pad sampled every clock cycle
// - Output pins follow output control bits
// - Atomic set, clear, toggle by writing ones
// - Input mode: no driver, Schmitt on, pulls
// - Alternate mode picks one of sixteen functions
// - Peripheral decides alternate pin direction
// - Additional functions override port configuration
// - Open-drain drives low only; push-pull both
// - Analog: all off, status reads zero
// - Alternate: peripheral drives, input still sampled
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter bit IS_PORT_A = 1'b1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] pad_pu,
  output logic [15:0] pad_pd,
  output logic [15:0] pad_schmitt_en,
  output logic [31:0] pad_speed,
  input wire logic [255:0] af_out_bus,
  input wire logic [255:0] af_oe_bus,
  output logic [255:0] af_in_bus,
  input wire logic [15:0] xfn_hw_out,
  input wire logic [15:0] xfn_hw_oe
);
  localparam logic [31:0] MODE_RST = IS_PORT_A ? GPP_MODE_RST_A : GPP_ZERO;
  localparam logic [31:0] PULL_RST = IS_PORT_A ? GPP_PULL_RST_A : GPP_ZERO;

  logic [31:0] port_mode_control_r;
  logic [15:0] port_output_type_r;
  logic [31:0] port_output_speed_r;
  logic [31:0] port_pull_select_r;
  logic [15:0] port_output_control_r;
  logic [31:0] alt_function_select_r [2];
  logic [15:0] port_xfn_enable_r;
  logic [15:0] port_input_status;
  logic [15:0] af_out_sel;
  logic [15:0] af_oe_sel;

  // Address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic req_valid;
  logic [31:0] rdata_nxt;

  assign req_valid = hsel && hready &&
    (htrans == GPP_HTRANS_NONSEQ || htrans == GPP_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= req_valid && hwrite;
      rd_pend_r <= req_valid && !hwrite;
      if (req_valid)
        addr_r <= {haddr[7:2], 2'b00};
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_mode_control_r <= MODE_RST;
      port_output_type_r <= 16'h0000;
      port_output_speed_r <= GPP_ZERO;
      port_pull_select_r <= PULL_RST;
      alt_function_select_r[0] <= GPP_ZERO;
      alt_function_select_r[1] <= GPP_ZERO;
      port_xfn_enable_r <= 16'h0000;
    end
    else if (wr_pend_r)
    begin
      case (addr_r)
        GPP_MODE_OFF: port_mode_control_r <= hwdata;
        GPP_OTYPE_OFF: port_output_type_r <= hwdata[15:0];
        GPP_SPEED_OFF: port_output_speed_r <= hwdata;
        GPP_PULL_OFF: port_pull_select_r <= hwdata;
        GPP_AFSEL0_OFF: alt_function_select_r[0] <= hwdata;
        GPP_AFSEL1_OFF: alt_function_select_r[1] <= hwdata;
        GPP_XFN_OFF: port_xfn_enable_r <= hwdata[15:0];
        default: port_mode_control_r <= port_mode_control_r;
      endcase
    end
  end

  // Output control with atomic operate registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_output_control_r <= 16'h0000;
    else if (wr_pend_r)
    begin
      case (addr_r)
        GPP_OCTL_OFF: port_output_control_r <= hwdata[15:0];
        // Upper half clears, lower half sets; set applied last so it wins
        GPP_BSET_OFF:
          port_output_control_r <= (port_output_control_r & ~hwdata[31:16])
            | hwdata[15:0];
        GPP_BCLR_OFF:
          port_output_control_r <= port_output_control_r & ~hwdata[15:0];
        GPP_TGL_OFF:
          port_output_control_r <= port_output_control_r ^ hwdata[15:0];
        default: port_output_control_r <= port_output_control_r;
      endcase
    end
  end

  // Read mux; operate registers are write-only and read zero
  always_comb
  begin
    case (addr_r)
      GPP_MODE_OFF: rdata_nxt = port_mode_control_r;
      GPP_OTYPE_OFF: rdata_nxt = {16'h0000, port_output_type_r};
      GPP_SPEED_OFF: rdata_nxt = port_output_speed_r;
      GPP_PULL_OFF: rdata_nxt = port_pull_select_r;
      GPP_ISTAT_OFF: rdata_nxt = {16'h0000, port_input_status};
      GPP_OCTL_OFF: rdata_nxt = {16'h0000, port_output_control_r};
      GPP_AFSEL0_OFF: rdata_nxt = alt_function_select_r[0];
      GPP_AFSEL1_OFF: rdata_nxt = alt_function_select_r[1];
      GPP_XFN_OFF: rdata_nxt = {16'h0000, port_xfn_enable_r};
      default: rdata_nxt = GPP_ZERO;
    endcase
  end

  assign hrdata = rd_pend_r ? rdata_nxt : GPP_ZERO;

  // Driver speed passes straight to the pads
  assign pad_speed = port_output_speed_r;

  genvar gi;
  generate
    for (gi = 0; gi < GPP_PINS; gi++)
    begin : g_pin
      logic [3:0] af_idx;
      logic [1:0] pin_mode_field;
      assign af_idx = alt_function_select_r[gi / 8][(gi % 8) * 4 +: 4];
      assign pin_mode_field = port_mode_control_r[gi * 2 +: 2];
      // One of sixteen peripheral functions per pin
      assign af_out_sel[gi] = af_out_bus[gi * 16 + af_idx];
      assign af_oe_sel[gi] = af_oe_bus[gi * 16 + af_idx];
      // Only the selected function sees the pad, and only in alternate mode
      assign af_in_bus[gi * 16 +: 16] = (pin_mode_field == GPP_MODE_AF) ?
        (16'h0001 << af_idx) & {16{port_input_status[gi]}} : 16'h0000;

      gpp_pin_cell u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(pin_mode_field),
        .otype(port_output_type_r[gi]),
        .pull(port_pull_select_r[gi * 2 +: 2]),
        .octl(port_output_control_r[gi]),
        .af_out(af_out_sel[gi]),
        .af_oe(af_oe_sel[gi]),
        .xfn_en(port_xfn_enable_r[gi]),
        .xfn_out(xfn_hw_out[gi]),
        .xfn_oe(xfn_hw_oe[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pad_pu(pad_pu[gi]),
        .pad_pd(pad_pd[gi]),
        .pad_schmitt_en(pad_schmitt_en[gi]),
        .istat(port_input_status[gi])
      );
    end
  endgenerate
endmodule

// ### rtl/gpp_pkg.sv
// Package for the 16-bit general-purpose port: register map, fields, reset values
package gpp_pkg;
  localparam int GPP_PINS = 16;
  // Register byte offsets
  localparam logic [7:0] GPP_MODE_OFF = 8'h00;
  localparam logic [7:0] GPP_OTYPE_OFF = 8'h04;
  localparam logic [7:0] GPP_SPEED_OFF = 8'h08;
  localparam logic [7:0] GPP_PULL_OFF = 8'h0C;
  localparam logic [7:0] GPP_ISTAT_OFF = 8'h10;
  localparam logic [7:0] GPP_OCTL_OFF = 8'h14;
  localparam logic [7:0] GPP_BSET_OFF = 8'h18;
  localparam logic [7:0] GPP_AFSEL0_OFF = 8'h20;
  localparam logic [7:0] GPP_AFSEL1_OFF = 8'h24;
  localparam logic [7:0] GPP_BCLR_OFF = 8'h28;
  localparam logic [7:0] GPP_TGL_OFF = 8'h2C;
  localparam logic [7:0] GPP_XFN_OFF = 8'h30;
  // Mode field encodings
  localparam logic [1:0] GPP_MODE_IN = 2'h0;
  localparam logic [1:0] GPP_MODE_OUT = 2'h1;
  localparam logic [1:0] GPP_MODE_AF = 2'h2;
  localparam logic [1:0] GPP_MODE_AN = 2'h3;
  // Pull field encodings
  localparam logic [1:0] GPP_PULL_NONE = 2'h0;
  localparam logic [1:0] GPP_PULL_UP = 2'h1;
  localparam logic [1:0] GPP_PULL_DOWN = 2'h2;
  // Reset values, port A with debug pins
  localparam logic [31:0] GPP_MODE_RST_A = 32'h2800_0000;
  localparam logic [31:0] GPP_PULL_RST_A = 32'h2400_0000;
  localparam logic [31:0] GPP_ZERO = 32'h0000_0000;
  // AHB encodings
  localparam logic [1:0] GPP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] GPP_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] GPP_HSIZE_WORD = 3'h2;
  // Pin input synchroniser depth
  localparam int GPP_SYNC_STAGES = 3;
endpackage

// ### rtl/gpp_pin_cell.sv
// Per-pin pad steering and input synchroniser for one port bit
`timescale 1ns/10ps
module gpp_pin_cell
  import gpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] mode,
  input wire logic otype,
  input wire logic [1:0] pull,
  input wire logic octl,
  input wire logic af_out,
  input wire logic af_oe,
  input wire logic xfn_en,
  input wire logic xfn_out,
  input wire logic xfn_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pu,
  output logic pad_pd,
  output logic pad_schmitt_en,
  output logic istat
);
  logic [GPP_SYNC_STAGES-1:0] sync_r;
  logic level_r;
  logic drv_val;
  logic drv_en;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_r <= '0;
    else
      sync_r <= {sync_r[GPP_SYNC_STAGES-2:0], pad_in};
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_r <= 1'b0;
    else if (sync_r[1] == sync_r[2])
      level_r <= sync_r[2];
  end

  always_comb
  begin
    drv_val = 1'b0;
    drv_en = 1'b0;
    case (mode)
      GPP_MODE_OUT:
      begin
        drv_val = octl;
        drv_en = 1'b1;
      end
      GPP_MODE_AF:
      begin
        drv_val = af_out;
        drv_en = af_oe;
      end
      default:
      begin
        drv_val = 1'b0;
        drv_en = 1'b0;
      end
    endcase
  end

  // Additional function wins over the port settings while enabled
  always_comb
  begin
    if (xfn_en)
    begin
      pad_out = xfn_out;
      pad_oe = xfn_oe;
      pad_pu = 1'b0;
      pad_pd = 1'b0;
      pad_schmitt_en = 1'b0;
    end
    else
    begin
      // Open drain only ever drives low; a one releases the pad
      pad_out = otype ? 1'b0 : drv_val;
      pad_oe = otype ? (drv_en & ~drv_val) : drv_en;
      pad_pu = (mode != GPP_MODE_AN) && (pull == GPP_PULL_UP);
      pad_pd = (mode != GPP_MODE_AN) && (pull == GPP_PULL_DOWN);
      pad_schmitt_en = (mode != GPP_MODE_AN);
    end
  end

  assign istat = (mode == GPP_MODE_AN) ? 1'b0 : level_r;
endmodule

// ### sim/gpp_port_monitor.sv
// Concurrent checks on the port's bus and pad pins
`timescale 1ns/10ps
module gpp_port_monitor(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pad_pu,
  input wire logic [15:0] pad_pd,
  input wire logic [31:0] pad_speed,
  input wire logic [255:0] af_oe_bus,
  input wire logic [255:0] af_in_bus
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans[1];
  wire rdq = tk && !hwrite;
  a_speed_copy: assert property (tk && hwrite && haddr[7:0] == 8'h08 ##1 1'b1 |=>
    pad_speed == $past(hwdata)) else $error("speed output differs from written word");
  a_op_zero: assert property (rdq && haddr[7:0] == 8'h2C |=> hrdata == 32'h0)
    else $error("toggle register read not zero");
  a_stat_upper: assert property (rdq && haddr[7:0] == 8'h10 |=> hrdata[31:16] == 16'h0)
    else $error("status upper half not zero");
  a_pull_excl: assert property ((pad_pu & pad_pd) == 16'h0)
    else $error("pull-up and pull-down both on");
  a_reset_quiet: assert property ($rose(hresetn) |-> !pad_oe[15] && pad_oe[12:0] == 13'h0)
    else $error("pin driven after reset");
  a_dbg_pulls: assert property ($rose(hresetn) |-> pad_pd[14] && pad_pu[13])
    else $error("debug pin pulls wrong after reset");
  a_dbg_af: assert property ($rose(hresetn) |->
    pad_oe[14:13] == {af_oe_bus[224], af_oe_bus[208]}) else $error("debug pins not steered");
  a_rdata_idle: assert property (!rdq |=> hrdata == 32'h0)
    else $error("read data shown outside a data phase");
  for (genvar i = 0; i < 16; i++)
  begin : g_af
    a_af_onehot: assert property ($onehot0(af_in_bus[i*16+:16]))
      else $error("more than one function sees the pin");
  end
endmodule
bind gpp_port gpp_port_monitor u_mon(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .pad_oe, .pad_pu, .pad_pd, .pad_speed, .af_oe_bus, .af_in_bus);

// ### sim/gpp_pad_model.sv
// Pad ring: pin level from driver, outside source or pulls
`timescale 1ns/10ps
module gpp_pad_model(
  input wire logic hclk,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pad_pu,
  input wire logic [15:0] pad_pd,
  input wire logic [15:0] ext_lvl,
  input wire logic [15:0] ext_on,
  output logic [15:0] pad_in
);
  logic [15:0] flt = 16'h0;
  // Floating pin wanders so a stale level never passes
  always @(posedge hclk) flt <= ~flt;
  always_comb
    for (int i = 0; i < 16; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_on[i] ? ext_lvl[i] :
        pad_pu[i] | (~pad_pd[i] & flt[i]);
endmodule

// ### sim/gpio_port_pin_config_test.sv
// Self-checking bench for the general-purpose port
`timescale 1ns/10ps
module gpio_port_pin_config_test import gpp_pkg::*;;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp, e;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, pad_speed;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = GPP_HSIZE_WORD;
  logic [15:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_sch;
  logic [15:0] xo = 16'h0, xe = 16'h0, ev = 16'h0, eo = 16'hFFFF;
  logic [255:0] afo = 256'h0, afe = 256'h0, afi;
  logic [31:0] m [16];
  int num_errors = 0, num_checks = 0;
  always #4 hclk = ~hclk;
  gpp_port dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pad_in, .pad_out, .pad_oe, .pad_pu,
    .pad_pd, .pad_schmitt_en(pad_sch), .pad_speed, .af_out_bus(afo), .af_oe_bus(afe),
    .af_in_bus(afi), .xfn_hw_out(xo), .xfn_hw_oe(xe));
  gpp_pad_model pads(.hclk, .pad_out, .pad_oe, .pad_pu, .pad_pd, .ext_lvl(ev), .ext_on(eo),
    .pad_in);
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task hw;
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      q = hrdata;
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      complete_run();
    end
    @(posedge hclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    htrans <= GPP_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hw();
    htrans <= 2'h0;
    hwdata <= d;
    hw();
    if (!w)
      chk("read", q, m[a[5:2]]);
    else if (a == GPP_BSET_OFF)
      m[5] = m[5] & ~{16'h0, d[31:16]} | {16'h0, d[15:0]};
    else if (a == GPP_BCLR_OFF)
      m[5] = m[5] & ~d;
    else if (a == GPP_TGL_OFF)
      m[5] = m[5] ^ (d & 32'hFFFF);
    else if (a inside {8'h00, 8'h08, 8'h0C, 8'h20, 8'h24})
      m[a[5:2]] = d;
    else if (a inside {8'h04, 8'h14, 8'h30})
      m[a[5:2]] = d & 32'hFFFF;
  endtask
  initial
  begin
    void'($urandom(32'h40859397));
    foreach (m[i]) m[i] = 32'h0;
    m[0] = GPP_MODE_RST_A;
    m[3] = GPP_PULL_RST_A;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 64; a += 4) wr(a[7:0], 32'h0, 1'b0);
    repeat (3)
    begin
      for (int a = 0; a < 52; a += 4) wr(a[7:0], $urandom);
      for (int a = 0; a < 52; a += 4)
        if (a != 16) wr(a[7:0], 32'h0, 1'b0);
      chk("speed", pad_speed, m[2]);
    end
    wr(GPP_XFN_OFF, 32'h0);
    wr(GPP_OTYPE_OFF, 32'h0);
    wr(GPP_MODE_OFF, 32'h55555555);
    wr(GPP_OCTL_OFF, $urandom);
    #1;
    chk("out", pad_out, m[5]);
    chk("oe", pad_oe, 32'hFFFF);
    wr(GPP_OTYPE_OFF, 32'hFFFF);
    #1;
    chk("od", pad_oe, ~m[5] & 32'hFFFF);
    ev <= 16'($urandom);
    wr(GPP_MODE_OFF, 32'h0);
    wr(GPP_PULL_OFF, 32'h0);
    repeat (6) @(posedge hclk);
    m[4] = {16'h0, ev};
    wr(GPP_ISTAT_OFF, 32'h0, 1'b0);
    chk("sch", pad_sch, 32'hFFFF);
    chk("oe", pad_oe, 32'h0);
    // Released pins: only the pull sets the level
    eo <= 16'h0;
    for (int p = 1; p < 3; p++)
    begin
      wr(GPP_PULL_OFF, {16{p[1:0]}});
      repeat (6) @(posedge hclk);
      m[4] = (p == 1) ? 32'hFFFF : 32'h0;
      wr(GPP_ISTAT_OFF, 32'h0, 1'b0);
    end
    eo <= 16'hFFFF;
    ev <= 16'hFFFF;
    wr(GPP_MODE_OFF, 32'hFFFFFFFF);
    repeat (6) @(posedge hclk);
    wr(GPP_ISTAT_OFF, 32'h0, 1'b0);
    chk("pd", pad_pd, 32'h0);
    chk("sch", pad_sch, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      afo[i*32+:32] <= $urandom;
      afe[i*32+:32] <= $urandom;
    end
    wr(GPP_OTYPE_OFF, 32'h0);
    wr(GPP_AFSEL0_OFF, 32'h76543210);
    wr(GPP_AFSEL1_OFF, 32'hFEDCBA98);
    wr(GPP_MODE_OFF, 32'hAAAAAAAA);
    repeat (6) @(posedge hclk);
    for (int i = 0; i < 16; i++)
    begin
      e = afe[i*17] ? afo[i*17] : ev[i];
      chk("af_oe", pad_oe[i], afe[i*17]);
      chk("af_in", afi[i*16+:16], 32'(e) << i);
    end
    xo <= 16'($urandom);
    xe <= 16'hFFFF;
    wr(GPP_XFN_OFF, 32'hFFFF);
    #1;
    chk("xfn", pad_out, xo);
    chk("resp", hresp, 32'h0);
    wr(GPP_XFN_OFF, 32'h0);
    #1;
    chk("back", pad_oe, {afe[255], afe[238], afe[221], afe[204], afe[187], afe[170],
      afe[153], afe[136], afe[119], afe[102], afe[85], afe[68], afe[51], afe[34],
      afe[17], afe[0]});
    complete_run();
  end
endmodule
